// [pss_map.vh]
// Constants for the pump status and error supervisor.
// Assumes a 50 MHz system clock; included by bare name.
`ifndef PSS_MAP_VH
`define PSS_MAP_VH

// ----------------------------------------------------------------
// Lamp colour codes
// ----------------------------------------------------------------
`define PSS_LAMP_OFF 2'h0
`define PSS_LAMP_GREEN 2'h1
`define PSS_LAMP_YELLOW 2'h2
`define PSS_LAMP_RED 2'h3

// ----------------------------------------------------------------
// Error cause codes in the event log
// ----------------------------------------------------------------
`define PSS_CAUSE_NONE 3'h0
`define PSS_CAUSE_FAULT 3'h1
`define PSS_CAUSE_SHUTDOWN 3'h2
`define PSS_CAUSE_REMOTE_TO 3'h3
`define PSS_CAUSE_SEQ_TO 3'h4
`define PSS_CAUSE_DONE_TO 3'h5

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define PSS_CLK_HZ 32'h02FAF080
`define PSS_MS_PER_S 32'h000003E8
`define PSS_REMOTE_TO_S 32'h0000003C
`define PSS_BLINK_HALF_MS 32'h000001F4

`endif

// [pss_log_mem.v]
// Event log memory of the supervisor: one write port, one read port.
// Assumes one clock; read data come out of a register.
`timescale 1ns/1ps

module pss_log_mem #(
  parameter AW = 4,
  parameter DW = 16
) (
  input wire clk,
  input wire wr_en,
  input wire [AW-1:0] wr_addr,
  input wire [DW-1:0] wr_data,
  input wire [AW-1:0] rd_addr,
  output reg [DW-1:0] rd_data
);

  reg [DW-1:0] mem [0:(1<<AW)-1];

  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule // pss_log_mem

// [pss_supervisor.v]
// Status lamp and error supervisor of the pump module.
// Assumes all inputs synchronous to clk; shut-down input active low.
`timescale 1ns/1ps
`include "pss_map.vh"

// Contract
// RL1 - Idle and ready with power: lamp dark.
// RL2 - Analysis run in progress: lamp steady green.
// RL3 - Not ready, including setpoint waits and self-test: steady yellow.
// RL4 - Internal fault such as leak or defective part: steady red.
// RL5 - Any error aborts a running analysis; no silent continuation.
// RL6 - Boot-resident firmware mode: lamp blinks yellow.
// RL7 - Severe fault during startup: lamp blinks red.
// RL8 - Every failure lights red and appends an event log record; one arriving while an error already stands is not logged.
// RL9 - Sequence run not-ready beyond timeout threshold raises timeout error.
// RL10 - Armed timeout after finished analysis switches pump off, reports timeout.
// RL11 - Shut-down input sampled continuously; low level raises shut-down error.
// RL12 - External instrument needing a stop drives the shut-down line low.
// RL13 - Remote not-ready must clear within one minute of start, else error.
// RL14 - Lamp priority: startup fail, error, resident, not-ready, run, idle.
// RL15 - Remote timer runs from start until not-ready clears; no restart.
module pss_supervisor #(
  // Sixty seconds and half a second of system clock by default
  parameter REMOTE_TO_CYCLES = `PSS_REMOTE_TO_S * `PSS_CLK_HZ,
  parameter BLINK_CYCLES = (`PSS_CLK_HZ / `PSS_MS_PER_S) * `PSS_BLINK_HALF_MS,
  parameter TO_W = 32,
  parameter LOG_AW = 4
) (
  input wire clk,
  input wire reset,
  input wire power_ok,
  input wire resident_mode,
  input wire startup_fail,
  input wire run_start,
  input wire run_end,
  input wire local_not_ready,
  input wire self_test,
  input wire internal_fault,
  input wire remote_shutdown_n,
  input wire remote_not_ready,
  input wire sequence_mode,
  input wire timeout_arm,
  input wire [TO_W-1:0] timeout_cycles,
  input wire error_clear,
  input wire [LOG_AW-1:0] log_rd_addr,
  output reg [1:0] lamp_colour,
  output wire running,
  output wire run_abort,
  output reg pump_enable,
  output reg error_active,
  output reg [2:0] error_cause,
  output wire error_event,
  output wire [LOG_AW-1:0] log_count,
  output wire [15:0] log_rd_data
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_DONE = 2'h2;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [31:0] remote_cnt_reg;
  reg remote_timing_reg;
  reg [TO_W-1:0] nr_cnt_reg;
  reg [TO_W-1:0] done_cnt_reg;
  reg [31:0] blink_cnt_reg;
  reg blink_reg;
  reg [LOG_AW-1:0] log_ptr_reg;
  reg [15:0] stamp_reg;
  reg error_active_next;

  // ----------------------------------------------------------------
  // Event decode
  // ----------------------------------------------------------------
  // Not-ready from any source; a running self-test counts as not ready

  wire not_ready = local_not_ready | self_test | remote_not_ready;
  wire ev_fault = internal_fault;
  wire ev_shutdown = ~remote_shutdown_n; // RL11
  wire ev_remote_to = remote_timing_reg & remote_not_ready &
                      (remote_cnt_reg == REMOTE_TO_CYCLES - 1); // RL13
  wire ev_seq_to = (state_reg == ST_RUN) & sequence_mode & not_ready &
                   (nr_cnt_reg == timeout_cycles); // RL9
  wire ev_done_to = (state_reg == ST_DONE) & timeout_arm &
                    (done_cnt_reg == timeout_cycles); // RL10
  wire any_ev = ev_fault | ev_shutdown | ev_remote_to | ev_seq_to | ev_done_to;

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // New error only on entry so the log holds one record per event
  assign error_event = any_ev & ~error_active; // RL8
  assign running = (state_reg == ST_RUN);
  assign run_abort = running & any_ev; // RL5
  assign log_count = log_ptr_reg;

  // ----------------------------------------------------------------
  // Run sequencing
  // ----------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        // Refused while an error stands or is arriving
        if (run_start && !error_active && !any_ev) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (any_ev) begin
          state_next = ST_IDLE; // RL5
        end else if (run_end) begin
          state_next = ST_DONE;
        end
      end
      ST_DONE: begin
        // An error after the run parks the sequencer in idle as well
        if (any_ev) begin
          state_next = ST_IDLE;
        end else if (run_start && !error_active) begin
          state_next = ST_RUN;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge clk) begin
    if (reset) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // Remote not-ready timer
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      remote_timing_reg <= 1'b0;
      remote_cnt_reg <= 32'h00000000;
    end else if (state_reg != ST_RUN && state_next == ST_RUN) begin
      // Armed on entry to run, from idle or after a finished run
      remote_timing_reg <= 1'b1; // RL15
      remote_cnt_reg <= 32'h00000000;
    end else if (remote_timing_reg) begin
      // Stops for good once the line clears; only a new start re-arms it
      if (!remote_not_ready || ev_remote_to || !running) begin
        remote_timing_reg <= 1'b0; // RL15
      end else begin
        remote_cnt_reg <= remote_cnt_reg + 32'h00000001; // RL13
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequence not-ready and post-run timeout counters
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      nr_cnt_reg <= {TO_W{1'b0}};
      done_cnt_reg <= {TO_W{1'b0}};
    end else begin
      // Both hold at the threshold so the event stays up until the state moves on
      if (running && sequence_mode && not_ready && nr_cnt_reg != timeout_cycles) begin
        nr_cnt_reg <= nr_cnt_reg + {{(TO_W-1){1'b0}}, 1'b1}; // RL9
      end else if (!(running && sequence_mode && not_ready)) begin
        nr_cnt_reg <= {TO_W{1'b0}};
      end
      // Post-run timer counts only while armed in the finished state
      if (state_reg == ST_DONE && timeout_arm && done_cnt_reg != timeout_cycles) begin
        done_cnt_reg <= done_cnt_reg + {{(TO_W-1){1'b0}}, 1'b1}; // RL10
      end else if (!(state_reg == ST_DONE && timeout_arm)) begin
        done_cnt_reg <= {TO_W{1'b0}};
      end
    end
  end

  // ----------------------------------------------------------------
  // Error latch, cause and pump control
  // ----------------------------------------------------------------
  always @* begin
    // A new event wins over a clear in the same cycle
    error_active_next = error_active;
    if (any_ev) begin
      error_active_next = 1'b1; // RL8
    end else if (error_clear) begin
      error_active_next = 1'b0;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      error_active <= 1'b0;
      error_cause <= `PSS_CAUSE_NONE;
      pump_enable <= 1'b1;
    end else begin
      error_active <= error_active_next;
      if (error_event) begin
        if (ev_fault) begin
          error_cause <= `PSS_CAUSE_FAULT;
        end else if (ev_shutdown) begin
          error_cause <= `PSS_CAUSE_SHUTDOWN;
        end else if (ev_remote_to) begin
          error_cause <= `PSS_CAUSE_REMOTE_TO;
        end else if (ev_seq_to) begin
          error_cause <= `PSS_CAUSE_SEQ_TO;
        end else begin
          error_cause <= `PSS_CAUSE_DONE_TO;
        end
      end else if (error_clear && !any_ev) begin
        error_cause <= `PSS_CAUSE_NONE;
      end
      // Post-run timeout turns the pump off; a new start turns it on
      if (ev_done_to) begin
        pump_enable <= 1'b0; // RL10
      end else if (run_start) begin
        pump_enable <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Event log
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      log_ptr_reg <= {LOG_AW{1'b0}};
      stamp_reg <= 16'h0000;
    end else begin
      // Free-running cycle stamp; a record keeps its low twelve bits
      stamp_reg <= stamp_reg + 16'h0001;
      if (error_event) begin
        log_ptr_reg <= log_ptr_reg + {{(LOG_AW-1){1'b0}}, 1'b1}; // RL8
      end
    end
  end

  wire [2:0] log_cause = ev_fault ? `PSS_CAUSE_FAULT :
                         ev_shutdown ? `PSS_CAUSE_SHUTDOWN :
                         ev_remote_to ? `PSS_CAUSE_REMOTE_TO :
                         ev_seq_to ? `PSS_CAUSE_SEQ_TO : `PSS_CAUSE_DONE_TO;

  // ----------------------------------------------------------------
  // Log memory
  // ----------------------------------------------------------------
  // One record is written on each new error, at the current count
  pss_log_mem #(
    .AW(LOG_AW),
    .DW(16)
  ) u_log (
    .clk(clk),
    .wr_en(error_event),
    .wr_addr(log_ptr_reg),
    .wr_data({1'b0, log_cause, stamp_reg[11:0]}),
    .rd_addr(log_rd_addr),
    .rd_data(log_rd_data)
  );

  // ----------------------------------------------------------------
  // Blink timebase
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (reset) begin
      blink_cnt_reg <= 32'h00000000;
      // Blinking lamps start dark
      blink_reg <= 1'b0;
    end else if (blink_cnt_reg == BLINK_CYCLES - 1) begin
      blink_cnt_reg <= 32'h00000000;
      blink_reg <= ~blink_reg;
    end else begin
      blink_cnt_reg <= blink_cnt_reg + 32'h00000001;
    end
  end

  // ----------------------------------------------------------------
  // Lamp
  // ----------------------------------------------------------------
  // Registered so the pin never glitches; red uses the next error value
  // so that it shows one edge after the event, together with error_active
  always @(posedge clk) begin
    if (reset) begin
      lamp_colour <= `PSS_LAMP_OFF;
    end else if (!power_ok) begin
      lamp_colour <= `PSS_LAMP_OFF;
    end else if (startup_fail) begin
      lamp_colour <= blink_reg ? `PSS_LAMP_RED : `PSS_LAMP_OFF; // RL7 RL14
    end else if (error_active_next) begin
      lamp_colour <= `PSS_LAMP_RED; // RL4 RL8 RL14
    end else if (resident_mode) begin
      lamp_colour <= blink_reg ? `PSS_LAMP_YELLOW : `PSS_LAMP_OFF; // RL6 RL14
    end else if (not_ready) begin
      lamp_colour <= `PSS_LAMP_YELLOW; // RL3 RL14
    end else if (state_next == ST_RUN) begin
      lamp_colour <= `PSS_LAMP_GREEN; // RL2
    end else begin
      lamp_colour <= `PSS_LAMP_OFF; // RL1
    end
  end

endmodule // pss_supervisor

// [pss_remote_model.sv]
// Model of the external instruments sharing the remote status lines.
// Assumes the bench drives the request inputs just after a falling edge.
`timescale 1ns/1ps

module pss_remote_model (
  input wire shut_req,
  input wire nr_req,
  output wire remote_shutdown_n,
  output wire remote_not_ready
);
  // -------------------------------------------------------------
  // Shared lines: shut-down pulled low on a stop, not-ready driven high on a request
  // -------------------------------------------------------------
  assign remote_shutdown_n = !shut_req;
  assign remote_not_ready = nr_req;
endmodule // pss_remote_model

// [pss_supervisor_chk.sv]
// Checker of the pump status supervisor, bound to its top module.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps

module pss_supervisor_chk (
  input wire clk,
  input wire reset,
  input wire power_ok,
  input wire startup_fail,
  input wire internal_fault,
  input wire remote_shutdown_n,
  input wire run_start,
  input wire error_clear,
  input wire running,
  input wire run_abort,
  input wire error_event,
  input wire error_active,
  input wire [2:0] error_cause,
  input wire [1:0] lamp_colour,
  input wire pump_enable,
  input wire [3:0] log_count
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // -------------------------------------------------------------
  // Properties
  // -------------------------------------------------------------
  property p_shut; !remote_shutdown_n && !error_active |-> error_event; endproperty
  a_shut: assert property (p_shut) else $error("shut-down low gave no event");
  property p_cause;
    !remote_shutdown_n && !error_active && !internal_fault |=> error_cause == 3'h2;
  endproperty
  a_cause: assert property (p_cause) else $error("wrong shut-down cause");
  property p_abort; running && error_event |-> run_abort ##1 !running; endproperty
  a_abort: assert property (p_abort) else $error("run not aborted");
  property p_keep; error_active && !error_clear |=> error_active; endproperty
  a_keep: assert property (p_keep) else $error("error dropped");
  property p_red; error_event && power_ok && !startup_fail |=> lamp_colour == 2'h3; endproperty
  a_red: assert property (p_red) else $error("lamp not red");
  property p_log; error_event |=> log_count == $past(log_count) + 4'h1; endproperty
  a_log: assert property (p_log) else $error("no log record");
  property p_off; !power_ok |=> lamp_colour == 2'h0; endproperty
  a_off: assert property (p_off) else $error("lamp lit without power");
  property p_blink;
    power_ok && startup_fail |=> lamp_colour == 2'h0 || lamp_colour == 2'h3;
  endproperty
  a_blink: assert property (p_blink) else $error("startup lamp not red");
  property p_start; run_start && !error_active && !error_event |=> running; endproperty
  a_start: assert property (p_start) else $error("run not started");
  property p_pump; run_start && !error_active && !error_event |=> pump_enable; endproperty
  a_pump: assert property (p_pump) else $error("pump not on");
endmodule // pss_supervisor_chk

bind pss_supervisor pss_supervisor_chk u_chk (.clk(clk), .reset(reset), .power_ok(power_ok),
  .startup_fail(startup_fail), .internal_fault(internal_fault),
  .remote_shutdown_n(remote_shutdown_n), .run_start(run_start), .error_clear(error_clear),
  .running(running), .run_abort(run_abort), .error_event(error_event),
  .error_active(error_active), .error_cause(error_cause), .lamp_colour(lamp_colour),
  .pump_enable(pump_enable), .log_count(log_count));

// [tb_pss.sv]
// Self-checking bench of the pump status supervisor.
// Assumes short remote timeout and blink counts set at the instance.
`timescale 1ns/1ps

module tb;
  reg clk = 1'b0;
  reg reset = 1'b1;
  reg power_ok = 1'b1, resident_mode = 1'b0, startup_fail = 1'b0, run_start = 1'b0;
  reg run_end = 1'b0, local_not_ready = 1'b0, self_test = 1'b0, internal_fault = 1'b0;
  reg sequence_mode = 1'b0, timeout_arm = 1'b0, error_clear = 1'b0;
  reg shut_req = 1'b0, nr_req = 1'b0;
  reg [31:0] timeout_cycles = 32'hA;
  reg [3:0] log_rd_addr = 4'h0;
  wire remote_shutdown_n, remote_not_ready, running, run_abort, pump_enable;
  wire error_active, error_event;
  wire [1:0] lamp_colour;
  wire [2:0] error_cause;
  wire [3:0] log_count;
  wire [15:0] log_rd_data;
  integer bad_count = 0;
  integer n_tests = 0;
  always #10 clk = ~clk;
  pss_remote_model u_pss_remote_model (.shut_req(shut_req), .nr_req(nr_req),
    .remote_shutdown_n(remote_shutdown_n), .remote_not_ready(remote_not_ready));
  pss_supervisor #(.REMOTE_TO_CYCLES(50), .BLINK_CYCLES(4)) u_pss_supervisor (.clk(clk),
    .reset(reset), .power_ok(power_ok), .resident_mode(resident_mode),
    .startup_fail(startup_fail), .run_start(run_start), .run_end(run_end),
    .local_not_ready(local_not_ready), .self_test(self_test),
    .internal_fault(internal_fault), .remote_shutdown_n(remote_shutdown_n),
    .remote_not_ready(remote_not_ready), .sequence_mode(sequence_mode),
    .timeout_arm(timeout_arm), .timeout_cycles(timeout_cycles), .error_clear(error_clear),
    .log_rd_addr(log_rd_addr), .lamp_colour(lamp_colour), .running(running),
    .run_abort(run_abort), .pump_enable(pump_enable), .error_active(error_active),
    .error_cause(error_cause), .error_event(error_event), .log_count(log_count),
    .log_rd_data(log_rd_data));
  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  task chk(input [15:0] seen, input [15:0] exp, input [8*6:1] nm);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("wrong value %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task cyc(input integer n); repeat (n) @(negedge clk); endtask
  task start; begin run_start = 1'b1; cyc(1); run_start = 1'b0; end endtask
  task stop; begin run_end = 1'b1; cyc(1); run_end = 1'b0; cyc(1); end endtask
  task clr; begin error_clear = 1'b1; cyc(1); error_clear = 1'b0; cyc(1); end endtask
  task see(input [1:0] col);
    integer i;
    reg [1:0] f;
    begin
      f = 2'h0;
      for (i = 0; i < 16; i = i + 1) begin
        cyc(1);
        if (lamp_colour === col) f[1] = 1'b1;
        if (lamp_colour === 2'h0) f[0] = 1'b1;
      end
      chk(f, 2'h3, "blink");
    end
  endtask
  task wrap_up;
    begin
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task t_run;
    begin
      cyc(2);
      chk(lamp_colour, 2'h0, "lamp");
      start; cyc(1);
      chk(lamp_colour, 2'h1, "lamp");
      local_not_ready = 1'b1; cyc(2);
      chk(lamp_colour, 2'h2, "lamp");
      local_not_ready = 1'b0; self_test = 1'b1; cyc(2);
      chk(lamp_colour, 2'h2, "lamp");
      self_test = 1'b0; stop; cyc(1);
      chk(lamp_colour, 2'h0, "lamp");
    end
  endtask
  task t_shut;
    begin
      start; cyc(2); shut_req = 1'b1; #1;
      chk(run_abort, 1'b1, "abort");
      chk(error_event, 1'b1, "event");
      cyc(1);
      chk(running, 1'b0, "run");
      chk(lamp_colour, 2'h3, "lamp");
      chk(error_cause, 3'h2, "cause");
      chk(log_count, 4'h1, "count");
      shut_req = 1'b0; cyc(2);
      chk(log_rd_data[14:12], 3'h2, "log");
      clr;
    end
  endtask
  task t_remote;
    begin
      nr_req = 1'b1; start; cyc(40);
      chk(error_active, 1'b0, "err");
      cyc(15);
      chk(error_cause, 3'h3, "cause");
      nr_req = 1'b0; clr;
      nr_req = 1'b1; start; cyc(20); nr_req = 1'b0; cyc(2); nr_req = 1'b1; cyc(60);
      chk(error_active, 1'b0, "err");
      nr_req = 1'b0; stop;
    end
  endtask
  task t_timeouts;
    begin
      sequence_mode = 1'b1; start; local_not_ready = 1'b1; cyc(8);
      chk(error_active, 1'b0, "err");
      cyc(6);
      chk(error_cause, 3'h4, "cause");
      local_not_ready = 1'b0; sequence_mode = 1'b0; clr;
      timeout_arm = 1'b1; start; cyc(2); stop; cyc(4);
      chk(pump_enable, 1'b1, "pump");
      cyc(10);
      chk(pump_enable, 1'b0, "pump");
      chk(error_cause, 3'h5, "cause");
      timeout_arm = 1'b0; clr; start;
      chk(pump_enable, 1'b1, "pump");
      stop;
    end
  endtask
  task t_lamp;
    begin
      resident_mode = 1'b1;
      see(2'h2);
      internal_fault = 1'b1; cyc(1); internal_fault = 1'b0; cyc(1);
      chk(lamp_colour, 2'h3, "lamp");
      chk(error_cause, 3'h1, "cause");
      chk(log_count, 4'h5, "count");
      log_rd_addr = 4'h4;
      cyc(2);
      chk(log_rd_data[14:12], 3'h1, "log");
      startup_fail = 1'b1;
      see(2'h3);
      power_ok = 1'b0; cyc(2);
      chk(lamp_colour, 2'h0, "lamp");
      power_ok = 1'b1; startup_fail = 1'b0; resident_mode = 1'b0; clr;
    end
  endtask
  initial begin
    #400000;
    bad_count = bad_count + 1;
    wrap_up;
  end
  initial begin
    cyc(16);
    reset = 1'b0;
    t_run;
    t_shut;
    t_remote;
    t_timeouts;
    t_lamp;
    wrap_up;
  end
endmodule // tb
